// *** prsc_defs.svh ***
// constants for the reset and suspend sequencer
`ifndef PRSC_DEFS_SVH
`define PRSC_DEFS_SVH

// ============================================================
// widths and depths
`define PRSC_DATA_W        8
`define PRSC_ADDR_W        3
`define PRSC_DEPTH         8
`define PRSC_NUM_PINS      3

// ============================================================
// field positions of the synchronised pin vector
`define PRSC_PIN_GLOBAL    0
`define PRSC_PIN_BUS       1
`define PRSC_PIN_SUSPEND   2

// ============================================================
// reset values
`define PRSC_REG_RST       8'h00
`define PRSC_PINS_RST      3'h7
`define PRSC_PME_RST       1'b0

// ============================================================
// timing counts, in core clock cycles
`define PRSC_SYNC_STAGES   3
`define PRSC_RD_LATENCY    2

`endif

// *** prsc_pkg.sv ***
// shared types of the reset and suspend sequencer
`default_nettype none
`include "prsc_defs.svh"

package prsc_pkg;

   // ============================================================
   // operating states
   typedef enum logic [1:0]
   {
      PRSC_ST_GLOBAL_RST,
      PRSC_ST_BUS_RST,
      PRSC_ST_RUN,
      PRSC_ST_SUSPEND
   } prsc_state_t;

   // ============================================================
   // raw control pins, all active low
   typedef struct packed
   {
      logic suspend_n;
      logic bus_reset_in_n;
      logic global_reset_in_n;
   } prsc_pins_t;

   // ============================================================
   // internal register access from the surrounding logic
   typedef struct packed
   {
      logic                      wr;
      logic                      rd;
      logic [`PRSC_ADDR_W-1:0]   addr;
      logic [`PRSC_DATA_W-1:0]   wdata;
   } prsc_req_t;

   // ============================================================
   // pin drive: value plus active-low enable
   typedef struct packed
   {
      logic [`PRSC_DATA_W-1:0]   data;
      logic                      data_oe_n;
      logic                      pme_out;
      logic                      pme_oe_n;
   } prsc_drive_t;

endpackage

`default_nettype wire

// *** prsc_regfile.sv ***
// internal register store with bulk clear and registered read
`timescale 1ns/1ps
`default_nettype none
`include "prsc_defs.svh"

module prsc_regfile
(
   input  wire logic                      i_core_clk,
   input  wire logic                      i_resetn,
   input  wire logic                      i_clr,
   input  wire logic                      i_we,
   input  wire logic [`PRSC_ADDR_W-1:0]   i_waddr,
   input  wire logic [`PRSC_DATA_W-1:0]   i_wdata,
   input  wire logic [`PRSC_ADDR_W-1:0]   i_raddr,
   output var  logic [`PRSC_DATA_W-1:0]   o_rdata
);

   // ============================================================
   // storage
   logic [`PRSC_DATA_W-1:0] mem_reg  [`PRSC_DEPTH];
   logic [`PRSC_DATA_W-1:0] mem_next [`PRSC_DEPTH];
   logic [`PRSC_DATA_W-1:0] rdata_reg;
   logic [`PRSC_DATA_W-1:0] rdata_next;

   // clear beats write so a reset never leaves a stray word
   always_comb
   begin
      for (int i = 0; i < `PRSC_DEPTH; i++)
      begin
         if (i_clr)
            mem_next[i] = `PRSC_REG_RST;
         else if (i_we && (i_waddr == i[`PRSC_ADDR_W-1:0]))
            mem_next[i] = i_wdata;
         else
            mem_next[i] = mem_reg[i];
      end
      rdata_next = i_clr ? `PRSC_REG_RST : mem_reg[i_raddr];
   end

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         for (int i = 0; i < `PRSC_DEPTH; i++)
            mem_reg[i] <= `PRSC_REG_RST;
         rdata_reg <= `PRSC_REG_RST;
      end
      else
      begin
         for (int i = 0; i < `PRSC_DEPTH; i++)
            mem_reg[i] <= mem_next[i];
         rdata_reg <= rdata_next;
      end
   end

   assign o_rdata = rdata_reg;

endmodule // prsc_regfile

`default_nettype wire

// *** prsc_seq.sv ***
// reset, suspend and pin-float sequencer for the bus-attached controller
`timescale 1ns/1ps
`default_nettype none
`include "prsc_defs.svh"

// Functional notes
// - global reset floats outputs, clears registers
// - global reset also clears wake context
// - bus reset keeps wake context across D3
// - suspend ignores global reset, keeps registers
// - suspend ignores bus reset, keeps registers
// - suspend floats every output
// - all bus pins sampled on rising edge
// - bus reset floats outputs, clears registers
// - no bus activity while bus reset held
// - operation restarts from defaults after release
module prsc_seq
   import prsc_pkg::*;
(
   input  wire logic                      i_core_clk,
   input  wire logic                      i_resetn,
   input  wire prsc_pins_t                i_pins,
   input  wire prsc_req_t                 i_req,
   input  wire logic                      i_bus_req,
   input  wire logic                      i_pme_event,
   input  wire logic                      i_pme_clr,
   output var  prsc_drive_t               o_drive,
   output var  logic [`PRSC_DATA_W-1:0]   o_rd_data,
   output var  logic                      o_rd_valid,
   output var  logic                      o_bus_grant,
   output var  logic                      o_pme_status,
   output var  prsc_state_t               o_state
);

   // ============================================================
   // pin synchronisers
   // pins arrive from outside the core clock; three stages each
   logic [`PRSC_NUM_PINS-1:0] pin_raw;
   logic [`PRSC_NUM_PINS-1:0] sync1_reg;
   logic [`PRSC_NUM_PINS-1:0] sync2_reg;
   logic [`PRSC_NUM_PINS-1:0] sync3_reg;
   logic [`PRSC_NUM_PINS-1:0] filt_reg;
   logic [`PRSC_NUM_PINS-1:0] filt_next;

   assign pin_raw = {i_pins.suspend_n,
                     i_pins.bus_reset_in_n,
                     i_pins.global_reset_in_n};

   // a change only counts once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < `PRSC_NUM_PINS; g++)
      begin : g_filt
         always_comb
         begin
            if (sync2_reg[g] == sync3_reg[g])
               filt_next[g] = sync3_reg[g];
            else
               filt_next[g] = filt_reg[g];
         end
      end
   endgenerate

   // rising-edge sampling of every pin
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         sync1_reg <= `PRSC_PINS_RST;
         sync2_reg <= `PRSC_PINS_RST;
         sync3_reg <= `PRSC_PINS_RST;
         filt_reg  <= `PRSC_PINS_RST;
      end
      else
      begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         filt_reg  <= filt_next;
      end
   end

   // ============================================================
   // state decode
   // filtered pins are active low; suspend outranks both resets
   function automatic prsc_state_t decode_state
   (
      input logic [`PRSC_NUM_PINS-1:0] pins
   );
      prsc_state_t st;
      st = PRSC_ST_RUN;
      if (!pins[`PRSC_PIN_SUSPEND])
         st = PRSC_ST_SUSPEND;
      else if (!pins[`PRSC_PIN_GLOBAL])
         st = PRSC_ST_GLOBAL_RST;
      else if (!pins[`PRSC_PIN_BUS])
         st = PRSC_ST_BUS_RST;
      return st;
   endfunction

   // of the four states, wake context is wiped only by the global reset state
   function automatic logic is_global_rst
   (
      input prsc_state_t st
   );
      return (st == PRSC_ST_GLOBAL_RST);
   endfunction

   // ============================================================
   // state machine
   prsc_state_t state_reg;
   prsc_state_t state_next;
   logic        clr_regs;
   logic        running;

   always_comb
   begin
      state_next = decode_state(filt_reg);
   end

   // idle pins reset deasserted, so reset leaves straight for run
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         state_reg <= PRSC_ST_GLOBAL_RST;
      else
         state_reg <= state_next;
   end

   // registers are cleared in either reset state, never in suspend
   always_comb
   begin
      case (state_reg)
         PRSC_ST_GLOBAL_RST:
         begin
            clr_regs = 1'b1;
            running  = 1'b0;
         end
         PRSC_ST_BUS_RST:
         begin
            clr_regs = 1'b1;
            running  = 1'b0;
         end
         PRSC_ST_SUSPEND:
         begin
            clr_regs = 1'b0;
            running  = 1'b0;
         end
         PRSC_ST_RUN:
         begin
            clr_regs = 1'b0;
            running  = 1'b1;
         end
         default:
         begin
            clr_regs = 1'b1;
            running  = 1'b0;
         end
      endcase
   end

   // ============================================================
   // internal register store
   logic                    we;
   logic [`PRSC_DATA_W-1:0] mem_rdata;

   // writes are dropped unless running, so suspend keeps contents
   assign we = running && i_req.wr;

   prsc_regfile u_regfile
   (
      .i_core_clk (i_core_clk),
      .i_resetn   (i_resetn),
      .i_clr      (clr_regs),
      .i_we       (we),
      .i_waddr    (i_req.addr),
      .i_wdata    (i_req.wdata),
      .i_raddr    (i_req.addr),
      .o_rdata    (mem_rdata)
   );

   // ============================================================
   // read path and returned read data
   logic                    rd_pend_reg;
   logic                    rd_pend_next;
   logic                    rd_valid_reg;
   logic                    rd_valid_next;
   logic [`PRSC_DATA_W-1:0] rd_data_reg;
   logic [`PRSC_DATA_W-1:0] rd_data_next;

   always_comb
   begin
      // a read in flight dies if the block leaves run
      rd_pend_next  = running && i_req.rd;
      rd_valid_next = running && rd_pend_reg;
      rd_data_next  = rd_valid_next ? mem_rdata : rd_data_reg;
      if (!running)
         rd_data_next = `PRSC_REG_RST;
   end

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rd_pend_reg  <= 1'b0;
         rd_valid_reg <= 1'b0;
         rd_data_reg  <= `PRSC_REG_RST;
      end
      else
      begin
         rd_pend_reg  <= rd_pend_next;
         rd_valid_reg <= rd_valid_next;
         rd_data_reg  <= rd_data_next;
      end
   end

   // ============================================================
   // bus activity
   // a grant lasts one cycle; a held request is granted again
   logic                    grant_reg;
   logic                    grant_next;

   always_comb
   begin
      grant_next = running && i_bus_req;
   end

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         grant_reg <= 1'b0;
      else
         grant_reg <= grant_next;
   end

   // ============================================================
   // wake context
   // only global reset and i_pme_clr in run clear it; bus reset and suspend keep it
   logic pme_reg;
   logic pme_next;

   always_comb
   begin
      pme_next = pme_reg;
      if (i_pme_clr && running)
         pme_next = 1'b0;
      // set beats clear: a wake landing with a clear is kept
      if (i_pme_event && !is_global_rst(state_reg))
         pme_next = 1'b1;
      if (is_global_rst(state_reg))
         pme_next = `PRSC_PME_RST;
   end

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         pme_reg <= `PRSC_PME_RST;
      else
         pme_reg <= pme_next;
   end

   // ============================================================
   // pin drive
   // every buffer floats unless running; enables are active low
   prsc_drive_t drive_reg;
   prsc_drive_t drive_next;

   // enables are registered, so they float one cycle after the state
   always_comb
   begin
      drive_next.data      = rd_data_next;
      drive_next.data_oe_n = ~rd_valid_next;
      drive_next.pme_out   = 1'b0;
      drive_next.pme_oe_n  = ~(running && pme_next);
   end

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         drive_reg.data      <= `PRSC_REG_RST;
         drive_reg.data_oe_n <= 1'b1;
         drive_reg.pme_out   <= 1'b0;
         drive_reg.pme_oe_n  <= 1'b1;
      end
      else
         drive_reg <= drive_next;
   end

   // ============================================================
   // outputs
   assign o_drive      = drive_reg;
   assign o_rd_data    = rd_data_reg;
   assign o_rd_valid   = rd_valid_reg;
   assign o_bus_grant  = grant_reg;
   assign o_pme_status = pme_reg;
   assign o_state      = state_reg;

endmodule // prsc_seq

`default_nettype wire

// *** prsc_seq_chk.sv ***
// port assertions for the reset and suspend sequencer
`timescale 1ns/1ps
`default_nettype none
`include "prsc_defs.svh"
module prsc_seq_chk
   import prsc_pkg::*;
(
   input  wire logic                     i_core_clk,
   input  wire logic                     i_resetn,
   input  wire prsc_pins_t               i_pins,
   input  wire prsc_req_t                i_req,
   input  wire logic                     i_bus_req,
   input  wire logic                     i_pme_event,
   input  wire prsc_drive_t              o_drive,
   input  wire logic [`PRSC_DATA_W-1:0]  o_rd_data,
   input  wire logic                     o_rd_valid,
   input  wire logic                     o_bus_grant,
   input  wire logic                     o_pme_status,
   input  wire prsc_state_t              o_state
);
   // ==========
   // relations
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   AST_FLOAT: assert property (
      o_state != PRSC_ST_RUN |=> o_drive.data_oe_n && o_drive.pme_oe_n)
      else $error("output driven outside run");
   AST_RD: assert property (
      (i_req.rd && o_state == PRSC_ST_RUN) ##1 o_state == PRSC_ST_RUN
      |=> o_rd_valid && !o_drive.data_oe_n)
      else $error("read answer missing");
   AST_NO_RD: assert property (
      o_rd_valid |-> $past(i_req.rd, 2))
      else $error("read answer without request");
   AST_GRANT: assert property (
      i_bus_req && o_state == PRSC_ST_RUN |=> o_bus_grant)
      else $error("grant missing");
   AST_NO_GRANT: assert property (
      o_state != PRSC_ST_RUN |=> !o_bus_grant)
      else $error("grant outside run");
   AST_GLOBAL_RESET_IN_PME: assert property (
      o_state == PRSC_ST_GLOBAL_RST |=> !o_pme_status)
      else $error("wake kept in global reset");
   AST_KEEP_PME: assert property (
      o_state inside {PRSC_ST_BUS_RST, PRSC_ST_SUSPEND} && !i_pme_event
      |=> $stable(o_pme_status))
      else $error("wake lost");
   AST_SUSP: assert property (
      (!i_pins.suspend_n) [*6] |-> o_state == PRSC_ST_SUSPEND)
      else $error("suspend not entered");
   AST_GLOBAL_RESET_IN: assert property (
      (i_pins.suspend_n && !i_pins.global_reset_in_n) [*6]
      |-> o_state == PRSC_ST_GLOBAL_RST)
      else $error("global reset not entered");
   AST_BRST: assert property (
      (i_pins.suspend_n && i_pins.global_reset_in_n
       && !i_pins.bus_reset_in_n) [*6] |-> o_state == PRSC_ST_BUS_RST)
      else $error("bus reset not entered");
   AST_RESTART: assert property (
      o_state == PRSC_ST_RUN && $past(o_state) == PRSC_ST_BUS_RST
      |-> o_rd_data == 8'h00 && !o_rd_valid)
      else $error("restart not from defaults");
endmodule // prsc_seq_chk
bind prsc_seq prsc_seq_chk u_chk (.i_core_clk, .i_resetn, .i_pins, .i_req,
   .i_bus_req, .i_pme_event, .o_drive, .o_rd_data, .o_rd_valid,
   .o_bus_grant, .o_pme_status, .o_state);
`default_nettype wire

// *** prsc_host_model.sv ***
// system side model driving the reset and suspend pins
`timescale 1ns/1ps
`default_nettype none
module prsc_host_model
   import prsc_pkg::*;
(
   input  wire logic  i_glob,
   input  wire logic  i_bus,
   input  wire logic  i_susp,
   input  wire logic  i_tie,
   output var  prsc_pins_t o_pins
);
   // ==========
   // pins, all active low
   always_comb
   begin
      o_pins.suspend_n = ~i_susp;
      o_pins.bus_reset_in_n = ~i_bus;
      // global on request, or tied to bus while i_tie is set
      o_pins.global_reset_in_n = ~(i_glob | (i_tie & i_bus));
   end
endmodule // prsc_host_model
`default_nettype wire

// *** prsc_seq_tb.sv ***
// self-checking bench for the reset and suspend sequencer
`timescale 1ns/1ps
`default_nettype none
module prsc_seq_tb
   import prsc_pkg::*;
;
   logic        clk, rstn, g, b, s, tie, bus_req, pme_ev, pme_clr;
   prsc_pins_t  pins;
   prsc_req_t   req;
   prsc_drive_t drv;
   logic [7:0]  rd_data;
   logic        rd_valid, grant, pme_st;
   prsc_state_t st;
   int          n_mismatch, checks_done, cyc_cnt;
   int          m[8];
   bit          pme_m;
   prsc_host_model host (.i_glob(g), .i_bus(b), .i_susp(s), .i_tie(tie),
      .o_pins(pins));
   prsc_seq dut (.i_core_clk(clk), .i_resetn(rstn), .i_pins(pins),
      .i_req(req), .i_bus_req(bus_req), .i_pme_event(pme_ev),
      .i_pme_clr(pme_clr), .o_drive(drv), .o_rd_data(rd_data),
      .o_rd_valid(rd_valid), .o_bus_grant(grant), .o_pme_status(pme_st),
      .o_state(st));
   // ==========
   // tasks
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wait_st(input prsc_state_t w);
      int k = 0;
      while (st !== w && k < 20)
      begin
         @(negedge clk);
         k++;
      end
      chk("state", 8'(st), 8'(w));
   endtask
   task automatic wr(input int a, input int d);
      prsc_state_t t = st;
      req.wr = 1'b1;
      req.addr = a[2:0];
      req.wdata = d[7:0];
      @(negedge clk);
      if (t === PRSC_ST_RUN)
         m[a] = d & 255;
   endtask
   task automatic wr_all;
      for (int a = 0; a < 8; a++)
         wr(a, $urandom);
      req.wr = 1'b0;
   endtask
   task automatic rd_all;
      for (int a = 0; a < 8; a++)
      begin
         req.rd = 1'b1;
         req.addr = a[2:0];
         @(negedge clk);
         req.rd = 1'b0;
         @(negedge clk);
         chk("valid", rd_valid, 8'h01);
         chk("data oe", drv.data_oe_n, 8'h00);
         chk("data pins", drv.data, 8'(m[a]));
         chk("rdata", rd_data, 8'(m[a]));
      end
   endtask
   task automatic grant_chk(input logic exp);
      bus_req = 1'b1;
      @(negedge clk);
      bus_req = 1'b0;
      chk("grant", grant, exp);
      @(negedge clk);
      chk("grant end", grant, 8'h00);
   endtask
   task automatic pme(input logic ev, input logic clr);
      pme_ev = ev;
      pme_clr = clr;
      @(negedge clk);
      pme_ev = 1'b0;
      pme_clr = 1'b0;
      pme_m = ev ? 1'b1 : (clr ? 1'b0 : pme_m);
      chk("pme", pme_st, pme_m);
      chk("pme oe", drv.pme_oe_n, !pme_m);
      chk("pme out", drv.pme_out, 8'h00);
   endtask
   task automatic float_chk;
      // enables are registered, so they float one cycle after the state
      @(negedge clk);
      chk("float", {drv.data_oe_n, drv.pme_oe_n}, 8'h03);
   endtask
   // ==========
   // clock, timeout, sequence
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc_cnt++;
      // generous: the sequence needs well under a thousand cycles
      if (cyc_cnt == 4000)
      begin
         n_mismatch++;
         final_report();
      end
   end
   initial
   begin
      void'($urandom(32'h9207));
      {g, b, s, tie, bus_req, pme_ev, pme_clr} = '0;
      req = '0;
      rstn = 1'b0;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      wait_st(PRSC_ST_RUN);
      rd_all();
      wr_all();
      rd_all();
      grant_chk(1'b1);
      pme(1'b1, 1'b0);
      b = 1'b1;
      wait_st(PRSC_ST_BUS_RST);
      float_chk();
      grant_chk(1'b0);
      wr(0, 8'h5A);
      req.wr = 1'b0;
      b = 1'b0;
      m = '{default:0};
      wait_st(PRSC_ST_RUN);
      chk("pme kept", pme_st, 8'h01);
      rd_all();
      wr_all();
      s = 1'b1;
      wait_st(PRSC_ST_SUSPEND);
      g = 1'b1;
      b = 1'b1;
      repeat (8) @(negedge clk);
      chk("susp", 8'(st), 8'(PRSC_ST_SUSPEND));
      float_chk();
      grant_chk(1'b0);
      g = 1'b0;
      b = 1'b0;
      repeat (6) @(negedge clk);
      s = 1'b0;
      wait_st(PRSC_ST_RUN);
      chk("pme susp", pme_st, 8'h01);
      rd_all();
      pme(1'b0, 1'b1);
      pme(1'b1, 1'b0);
      g = 1'b1;
      wait_st(PRSC_ST_GLOBAL_RST);
      repeat (2) @(negedge clk);
      chk("pme glob", pme_st, 8'h00);
      float_chk();
      g = 1'b0;
      m = '{default:0};
      pme_m = 1'b0;
      wait_st(PRSC_ST_RUN);
      rd_all();
      pme(1'b1, 1'b0);
      tie = 1'b1;
      b = 1'b1;
      wait_st(PRSC_ST_GLOBAL_RST);
      repeat (2) @(negedge clk);
      chk("pme tied", pme_st, 8'h00);
      final_report();
   end
endmodule // prsc_seq_tb
`default_nettype wire
